/* can_node_model.sv */
// far side node: takes transmitted frames, sends received frames
`timescale 1ns/100ps
`default_nettype none

module can_node_model
  import can_pack_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       stall,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire can_frame_s tx_frame,
  output logic            got,
  output can_frame_s      got_frame,
  output logic            rx_valid,
  output can_frame_s      rx_frame
);
  // receive strobe idle before the first send; ready and got reset below
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end

  // ready moves only after an edge; stall models a busy controller
  always @(posedge ref_clk) begin
    tx_ready  <= !stall && !rst;
    got       <= tx_valid && tx_ready && !rst;
    got_frame <= tx_frame;
  end

  // one-cycle strobe; data inverted after so stale bits never match
  task automatic send(input logic [28:0] id, input logic [63:0] data);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_frame <= {id, data};
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_frame <= ~{id, data};
  endtask
endmodule

`default_nettype wire

/* can_pack_params.svh */
// constants for the can signal packer and unpacker
`ifndef CAN_PACK_PARAMS_SVH
`define CAN_PACK_PARAMS_SVH

// clock and millisecond timing
`define CLK_PERIOD_NS   4
`define MS_IN_NS        1000000
`define MS_CYCLES       (`MS_IN_NS / `CLK_PERIOD_NS)

// transmit defaults
`define TX_MSG_COUNT    16
`define TX_SIG_COUNT    4
`define RTD_CHANNELS    12
`define DEF_PRIO        3'h6
`define DEF_PGN_BASE    16'hFF00
`define AVG_MSG         4'hC
`define AVG_PGN         16'hFD53
`define AVG_SRC         5'h0D
`define DEF_SIG1_BYTE   3'h2
`define DEF_BYTE        3'h0
`define DEF_BIT         3'h0
`define DEF_RES         32'sh00000001
`define DEF_OFFSET      32'sh00000000
`define DEF_MIN         (-32'sh05F5E100)
`define DEF_MAX         32'sh05F5E100
`define MAX_PERIOD_MS   16'hFDE8

// receive defaults
`define DEF_SRC_ADDR    8'hFE
`define DEF_OFF_THR     32'sh00000000
`define DEF_ON_THR      32'sh000007D0
`define MAX_TIMEOUT_MS  16'hEA60
`define PDU2_PF_MIN     8'hF0

`endif

/* can_pack_pkg.sv */
// types shared by the can signal packer and unpacker
package can_pack_pkg;

  // field width selection for a packed signal
  typedef enum logic [2:0] {
    SZ_1BIT, SZ_2BIT, SZ_4BIT, SZ_1BYTE, SZ_2BYTE, SZ_3BYTE, SZ_4BYTE
  } size_e;

  // transmit sequencer states
  typedef enum logic [1:0] {S_IDLE, S_BUILD, S_PUSH} tx_state_e;

  // per-signal transmit setup; values are in thousandths
  typedef struct packed {
    logic [4:0]         src;       // 0 = unused, 1..16 = source input
    size_e              size;
    logic [2:0]         byte_idx;
    logic [2:0]         bit_idx;
    logic signed [31:0] res;
    logic signed [31:0] offset;
    logic signed [31:0] min;
    logic signed [31:0] max;
  } sig_cfg_s;

  // per-message transmit setup
  typedef struct packed {
    logic [15:0] pgn;
    logic [2:0]  prio;
    logic [15:0] period_ms;
  } msg_cfg_s;

  // receive message setup
  typedef struct packed {
    logic [15:0]        pgn;
    logic [15:0]        timeout_ms;
    logic               filt_en;
    logic [7:0]         src_addr;
    size_e              size;
    logic [2:0]         byte_idx;
    logic [2:0]         bit_idx;
    logic signed [31:0] res;
    logic signed [31:0] offset;
    logic signed [31:0] off_thr;
    logic signed [31:0] on_thr;
  } rx_cfg_s;

  // general fault options
  typedef struct packed {
    logic pf_disables;
    logic ot_shutdown;
  } gen_opt_s;

  // one extended can frame
  typedef struct packed {
    logic [28:0] id;
    logic [63:0] data;
  } can_frame_s;

endpackage

/* can_signal_pack.sv */
// can signal packer, unpacker, receive supervisor and fault gating
`timescale 1ns/100ps
`default_nettype none
`include "can_pack_params.svh"

module can_signal_pack
  import can_pack_pkg::*;
#(
  parameter int         MS_CYCLES = `MS_CYCLES,
  parameter logic [7:0] OWN_SA    = 8'h80
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [15:0][31:0] src_val_i,
  input  wire logic              tx_cfg_we,
  input  wire logic [3:0]        tx_cfg_msg,
  input  wire msg_cfg_s          tx_cfg_i,
  input  wire logic              sig_cfg_we,
  input  wire logic [3:0]        sig_cfg_msg,
  input  wire logic [1:0]        sig_cfg_idx,
  input  wire sig_cfg_s          sig_cfg_i,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output can_frame_s             tx_frame,
  input  wire logic              rx_valid,
  input  wire can_frame_s        rx_frame,
  input  wire rx_cfg_s           rx_cfg_i,
  output logic signed [31:0]     rx_value_o,
  output logic                   rx_state_o,
  output logic                   rx_fresh_o,
  output logic                   rx_timeout_o,
  input  wire gen_opt_s          gen_opt_i,
  input  wire logic              power_fault,
  input  wire logic              over_temp,
  output logic                   outputs_disabled_o,
  output logic                   shutdown_o
);

  localparam int NM = `TX_MSG_COUNT;
  localparam int NS = `TX_SIG_COUNT;

  // width in bits of a size selection
  function automatic logic [5:0] size_bits(size_e s);
    case (s)
      SZ_1BIT:  size_bits = 6'h01;
      SZ_2BIT:  size_bits = 6'h02;
      SZ_4BIT:  size_bits = 6'h04;
      SZ_1BYTE: size_bits = 6'h08;
      SZ_3BYTE: size_bits = 6'h18;
      SZ_4BYTE: size_bits = 6'h20;
      default:  size_bits = 6'h10;
    endcase
  endfunction

  // mask of the low n bits, n up to 32
  function automatic logic [63:0] low_mask(logic [5:0] n);
    low_mask = (64'h1 << n) - 64'h1;
  endfunction

  // reset-time signal setup; only signal 1 of the first 13 is bound
  function automatic sig_cfg_s def_sig(int m, int s);
    def_sig          = '0;
    def_sig.size     = SZ_2BYTE;
    def_sig.byte_idx = (s == 0) ? `DEF_SIG1_BYTE : `DEF_BYTE;
    def_sig.bit_idx  = `DEF_BIT;
    def_sig.res      = `DEF_RES;
    def_sig.offset   = `DEF_OFFSET;
    def_sig.min      = `DEF_MIN;
    def_sig.max      = `DEF_MAX;
    if (s == 0 && m < `RTD_CHANNELS) begin
      def_sig.src = 5'(m + 1);
    end else if (s == 0 && m == int'(`AVG_MSG)) begin
      def_sig.src = `AVG_SRC;
    end
  endfunction

  // reset-time message header
  function automatic msg_cfg_s def_msg(int m);
    def_msg           = '0;
    def_msg.pgn       = (m == int'(`AVG_MSG)) ? `AVG_PGN
                        : `DEF_PGN_BASE | 16'(m);
    def_msg.prio      = `DEF_PRIO;
    def_msg.period_ms = '0;
  endfunction

  // reset-time receive setup: off, null sender, two bytes, 0.001
  function automatic rx_cfg_s def_rx();
    def_rx          = '0;
    def_rx.src_addr = `DEF_SRC_ADDR;
    def_rx.size     = SZ_2BYTE;
    def_rx.res      = `DEF_RES;
    def_rx.offset   = `DEF_OFFSET;
    def_rx.off_thr  = `DEF_OFF_THR;
    def_rx.on_thr   = `DEF_ON_THR;
  endfunction

  // clamp, then raw = (value - offset) / resolution
  function automatic logic [31:0] tx_raw(sig_cfg_s c,
                                         logic signed [31:0] v);
    logic signed [31:0] t;
    t = v;
    if (t < c.min) t = c.min;
    if (t > c.max) t = c.max;
    tx_raw = (c.res == 0) ? '0 : 32'((t - c.offset) / c.res);
  endfunction

  // pad field into payload at byte*8+bit; overhang past 64 is lost
  function automatic logic [63:0] ins(logic [63:0] p, sig_cfg_s c,
                                      logic [31:0] raw);
    logic [5:0]  pos;
    logic [63:0] m;
    pos = {c.byte_idx, c.bit_idx};
    m   = low_mask(size_bits(c.size));
    ins = (p & ~(m << pos)) | (({32'h0, raw} & m) << pos);
  endfunction

  // --- configuration store -------------------------------------------
  msg_cfg_s msg_q [NM];
  msg_cfg_s msg_d [NM];
  sig_cfg_s sig_q [NM][NS];
  sig_cfg_s sig_d [NM][NS];

  // writes land on one message or one signal; bounds are sanitised
  always_comb begin
    for (int m = 0; m < NM; m++) begin
      msg_d[m] = msg_q[m];
      for (int s = 0; s < NS; s++) begin
        sig_d[m][s] = sig_q[m][s];
      end
    end
    if (tx_cfg_we) begin
      msg_d[tx_cfg_msg] = tx_cfg_i;
      if (tx_cfg_i.period_ms > `MAX_PERIOD_MS) begin
        msg_d[tx_cfg_msg].period_ms = `MAX_PERIOD_MS;
      end
    end
    if (sig_cfg_we) begin
      sig_d[sig_cfg_msg][sig_cfg_idx] = sig_cfg_i;
      if (sig_cfg_i.min > sig_cfg_i.max) begin
        sig_d[sig_cfg_msg][sig_cfg_idx].min = sig_cfg_i.max;
      end
    end
  end

  // reset loads the factory binding
  always_ff @(posedge ref_clk) begin
    for (int m = 0; m < NM; m++) begin
      msg_q[m] <= rst ? def_msg(m) : msg_d[m];
      for (int s = 0; s < NS; s++) begin
        sig_q[m][s] <= rst ? def_sig(m, s) : sig_d[m][s];
      end
    end
  end

  // --- fault pins: two-stage synchronisers ---------------------------
  logic [1:0] pf_sync_q, ot_sync_q;
  logic       halt;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pf_sync_q          <= '0;
      ot_sync_q          <= '0;
      outputs_disabled_o <= 1'b0;
      shutdown_o         <= 1'b0;
    end else begin
      pf_sync_q          <= {pf_sync_q[0], power_fault};
      ot_sync_q          <= {ot_sync_q[0], over_temp};
      outputs_disabled_o <= gen_opt_i.pf_disables && pf_sync_q[1];
      shutdown_o         <= gen_opt_i.ot_shutdown && ot_sync_q[1];
    end
  end

  // a shut-down unit starts no new frame; frames already built or buffered still go out
  assign halt = shutdown_o;

  // --- millisecond tick ----------------------------------------------
  logic [31:0] ms_cnt_q, ms_cnt_d;
  logic        ms_tick;

  assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));

  always_comb begin
    ms_cnt_d = ms_tick ? '0 : ms_cnt_q + 32'h1;
  end

  always_ff @(posedge ref_clk) begin
    ms_cnt_q <= rst ? '0 : ms_cnt_d;
  end

  // --- periodic scheduler and frame builder ---------------------------
  logic [15:0] per_q [NM];
  logic [15:0] per_d [NM];
  logic [NM-1:0] pend_q, pend_d;
  tx_state_e   st_q, st_d;
  logic [3:0]  cur_q, cur_d, pick;
  logic [1:0]  idx_q, idx_d;
  logic [63:0] pay_q, pay_d;
  logic        take;
  logic        push_valid;
  logic        push_ready;
  sig_cfg_s    sc;
  can_frame_s  push_frame;

  // lowest numbered pending message goes first
  always_comb begin
    pick = '0;
    for (int m = NM - 1; m >= 0; m--) begin
      if (pend_q[m]) pick = 4'(m);
    end
  end

  assign sc = sig_q[cur_q][idx_q];

  // sequencer: one signal per cycle, then wait for buffer room
  always_comb begin
    st_d       = st_q;
    cur_d      = cur_q;
    idx_d      = idx_q;
    pay_d      = pay_q;
    take       = 1'b0;
    push_valid = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (|pend_q && !halt) begin
          st_d  = S_BUILD;
          cur_d = pick;
          idx_d = '0;
          pay_d = '0;
          take  = 1'b1;
        end
      end
      S_BUILD: begin
        if (sc.src != '0) begin
          pay_d = ins(pay_q, sc, tx_raw(sc, src_val_i[4'(sc.src - 1)]));
        end
        idx_d = idx_q + 2'h1;
        if (idx_q == 2'(NS - 1)) st_d = S_PUSH;
      end
      S_PUSH: begin
        push_valid = 1'b1;
        if (push_ready) st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  // frame id: priority, dp=0, pgn, own source address; then payload
  assign push_frame = {msg_q[cur_q].prio, 2'b00, msg_q[cur_q].pgn,
                       OWN_SA, pay_q};

  // countdown per message; a new period wins over the take
  always_comb begin
    for (int m = 0; m < NM; m++) begin
      per_d[m]  = per_q[m];
      pend_d[m] = pend_q[m] && !(take && cur_d == 4'(m));
      if (ms_tick) begin
        if (msg_q[m].period_ms == '0) begin
          per_d[m]  = '0;
          pend_d[m] = 1'b0;
        end else if (per_q[m] <= 16'h1) begin
          per_d[m]  = msg_q[m].period_ms;
          pend_d[m] = 1'b1;
        end else begin
          per_d[m]  = per_q[m] - 16'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q   <= S_IDLE;
      cur_q  <= '0;
      idx_q  <= '0;
      pay_q  <= '0;
      pend_q <= '0;
      for (int m = 0; m < NM; m++) per_q[m] <= '0;
    end else begin
      st_q   <= st_d;
      cur_q  <= cur_d;
      idx_q  <= idx_d;
      pay_q  <= pay_d;
      pend_q <= pend_d;
      for (int m = 0; m < NM; m++) per_q[m] <= per_d[m];
    end
  end

  // buffer keeps a stalled controller from costing a frame
  frame_buffer2 #(.WIDTH($bits(can_frame_s)), .DEPTH(2)) u_buf (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_frame),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_frame)
  );

  // --- receive path --------------------------------------------------
  logic [15:0]        rx_pgn;
  logic [31:0]        rx_raw;
  logic               rx_en, rx_hit;
  logic [15:0]        age_q, age_d, tmo;
  logic signed [31:0] val_d;
  logic signed [63:0] prod;
  logic               state_d, fresh_d, tmo_d;
  rx_cfg_s            rx_cfg_q;    // setup copy; reset loads defaults

  // registered setup so reset brings up the null sender and defaults
  always_ff @(posedge ref_clk) begin
    rx_cfg_q <= rst ? def_rx() : rx_cfg_i;
  end

  // pdu1 frames carry a destination in ps, which is not pgn
  assign rx_pgn = (rx_frame.id[23:16] < `PDU2_PF_MIN)
                  ? {rx_frame.id[23:16], 8'h00} : rx_frame.id[23:8];
  assign tmo    = (rx_cfg_q.timeout_ms > `MAX_TIMEOUT_MS)
                  ? `MAX_TIMEOUT_MS : rx_cfg_q.timeout_ms;
  assign rx_en  = (tmo != '0);
  assign rx_hit = rx_valid && rx_en && rx_pgn == rx_cfg_q.pgn
                  && (!rx_cfg_q.filt_en
                      || rx_frame.id[7:0] == rx_cfg_q.src_addr);
  assign rx_raw = 32'((rx_frame.data >> {rx_cfg_q.byte_idx,
                   rx_cfg_q.bit_idx}) & low_mask(size_bits(rx_cfg_q.size)));
  assign prod   = $signed({1'b0, rx_raw}) * rx_cfg_q.res;

  // scale, apply hysteresis and watch the age of the last hit
  always_comb begin
    val_d   = rx_value_o;
    state_d = rx_state_o;
    fresh_d = 1'b0;
    tmo_d   = 1'b0;
    age_d   = age_q;
    if (!rx_en) begin
      age_d = '0;
    end else if (rx_hit) begin
      val_d   = prod[31:0] + rx_cfg_q.offset;
      fresh_d = 1'b1;
      age_d   = '0;
    end else if (ms_tick) begin
      if (age_q + 16'h1 >= tmo) begin
        tmo_d = 1'b1;
        age_d = '0;
      end else begin
        age_d = age_q + 16'h1;
      end
    end
    if (val_d >= rx_cfg_q.on_thr) state_d = 1'b1;
    else if (val_d <= rx_cfg_q.off_thr) state_d = 1'b0;
    if (outputs_disabled_o) state_d = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_value_o   <= '0;
      rx_state_o   <= 1'b0;
      rx_fresh_o   <= 1'b0;
      rx_timeout_o <= 1'b0;
      age_q        <= '0;
    end else begin
      rx_value_o   <= val_d;
      rx_state_o   <= state_d;
      rx_fresh_o   <= fresh_d;
      rx_timeout_o <= tmo_d;
      age_q        <= age_d;
    end
  end

  // --- checks ---------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence build_start;
    st_q == S_IDLE && st_d == S_BUILD;
  endsequence
  sequence four_signals;
    (st_q == S_BUILD) [*4] ##1 st_q == S_PUSH;
  endsequence

  reset_binding_a: assert property ($fell(rst) |->
    msg_q[`AVG_MSG].pgn == `AVG_PGN && sig_q[0][0].src == 5'h01
    && sig_q[11][0].src == 5'h0C)
    else $error("factory binding not loaded");
  build_steps_a: assert property (build_start |=> four_signals)
    else $error("frame not built from four signal slots");
  zero_period_a: assert property (build_start |->
    msg_q[pick].period_ms != '0)
    else $error("message with zero interval was scheduled");
  frame_prio_a: assert property (push_valid |->
    push_frame.id[28:26] == msg_q[cur_q].prio)
    else $error("frame priority differs from setup");
  rx_disabled_a: assert property (rx_valid && !rx_en |=> !rx_fresh_o)
    else $error("reception while timeout is zero");
  rx_defaults_a: assert property ($fell(rst) |->
    rx_cfg_q.src_addr == 8'hFE && rx_cfg_q.timeout_ms == '0)
    else $error("receive setup not at defaults after reset");
  src_filter_a: assert property (rx_valid && rx_cfg_q.filt_en
    && rx_frame.id[7:0] != rx_cfg_q.src_addr |=> !rx_fresh_o)
    else $error("frame from wrong sender accepted");
  on_thr_a: assert property (rx_fresh_o && !$past(outputs_disabled_o)
    && rx_value_o >= rx_cfg_q.on_thr |-> rx_state_o)
    else $error("state not on above on threshold");
  off_thr_a: assert property (rx_fresh_o
    && rx_value_o <= rx_cfg_q.off_thr && rx_value_o < rx_cfg_q.on_thr
    |-> !rx_state_o)
    else $error("state not off below off threshold");
  pf_gate_a: assert property (outputs_disabled_o |=> !rx_state_o)
    else $error("outputs not disabled on power fault");
  ot_halt_a: assert property (shutdown_o && st_q == S_IDLE
    |=> st_q == S_IDLE)
    else $error("transmit started during shutdown");
  timeout_flag_a: assert property (rx_timeout_o |->
    $past(rx_en) && $past(ms_tick) && !rx_fresh_o)
    else $error("timeout flagged without an elapsed interval");

endmodule

`default_nettype wire

/* can_signal_pack_tb.sv */
// self-checking bench for the can signal packer and unpacker
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  error_cnt++; $display("wrong value at %0t: %h vs %h", $time, a, b); \
  end end

module can_signal_pack_tb import can_pack_pkg::*;;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic [15:0][31:0] src_val_i = '0;
  logic              tx_cfg_we = 1'b0, sig_cfg_we = 1'b0;
  logic [3:0]        tx_cfg_msg = '0, sig_cfg_msg = '0;
  logic [1:0]        sig_cfg_idx = '0;
  msg_cfg_s          tx_cfg_i = '0;
  sig_cfg_s          sig_cfg_i = '0;
  rx_cfg_s           rx_cfg_i = '0;
  gen_opt_s          gen_opt_i = '0;
  logic              power_fault = 1'b0, over_temp = 1'b0, stall = 1'b0;
  logic              tx_valid, tx_ready, rx_valid, got, rx_state_o;
  logic              rx_fresh_o, rx_timeout_o, outputs_disabled_o, shutdown_o;
  logic signed [31:0] rx_value_o;
  can_frame_s        tx_frame, rx_frame, got_frame, ef;
  can_frame_s        txq[$];    // expected frames, oldest first
  logic [32:0]       rxq[$];    // expected {state, value}
  logic [32:0]       rn;
  int                error_cnt = 0, checks_done = 0, got_n = 0, to_n = 0;

  // 250 MHz
  always #2 ref_clk = ~ref_clk;

  can_signal_pack #(.MS_CYCLES(10), .OWN_SA(8'h80)) uut (
    .ref_clk(ref_clk), .rst(rst), .src_val_i(src_val_i),
    .tx_cfg_we(tx_cfg_we), .tx_cfg_msg(tx_cfg_msg), .tx_cfg_i(tx_cfg_i),
    .sig_cfg_we(sig_cfg_we), .sig_cfg_msg(sig_cfg_msg),
    .sig_cfg_idx(sig_cfg_idx), .sig_cfg_i(sig_cfg_i),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_cfg_i(rx_cfg_i),
    .rx_value_o(rx_value_o), .rx_state_o(rx_state_o),
    .rx_fresh_o(rx_fresh_o), .rx_timeout_o(rx_timeout_o),
    .gen_opt_i(gen_opt_i), .power_fault(power_fault), .over_temp(over_temp),
    .outputs_disabled_o(outputs_disabled_o), .shutdown_o(shutdown_o));

  can_node_model far_node (
    .ref_clk(ref_clk), .rst(rst), .stall(stall), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_frame(tx_frame), .got(got),
    .got_frame(got_frame), .rx_valid(rx_valid), .rx_frame(rx_frame));

  // every taken frame or fresh value consumes the oldest note
  always @(posedge ref_clk) begin
    if (got) begin
      got_n++;
      if (txq.size() == 0) `CHK(got, 1'b0)
      else begin
        ef = txq.pop_front();
        `CHK(got_frame, ef)
      end
    end
    if (rx_fresh_o) begin
      if (rxq.size() == 0) `CHK(rx_fresh_o, 1'b0)
      else begin
        rn = rxq.pop_front();
        `CHK({rx_state_o, rx_value_o}, rn)
      end
    end
    if (rx_timeout_o) to_n++;
  end

  // counts, verdict, end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one message setup write, priority six
  task automatic wr_msg(input int m, input logic [15:0] pgn, per);
    @(posedge ref_clk);
    tx_cfg_we  <= 1'b1;
    tx_cfg_msg <= 4'(m);
    tx_cfg_i   <= '{pgn: pgn, prio: 3'h6, period_ms: per};
    @(posedge ref_clk);
    tx_cfg_we  <= 1'b0;
  endtask

  // bounded wait for the taken-frame count
  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (got_n < n && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    if (got_n < n) begin
      `CHK(got_n, n)
      stop_test();
    end
  endtask

  function automatic can_frame_s fexp(input logic [15:0] pgn,
                                      input logic [63:0] d);
    return {3'h6, 2'b00, pgn, 8'h80, d};
  endfunction

  initial begin
    int v, c, r, w, b, t, n;
    logic [63:0] d;
    logic [15:0] raw[3];
    logic [32:0] ex[3];
    raw = '{16'h0320, 16'h0028, 16'h0014};
    ex  = '{33'h100000959, 33'h100000071, 33'h000000035};
    void'($urandom(32'h2C1FB717));
    for (int k = 0; k < 16; k++) src_val_i[k] <= 32'($urandom % 30000);
    tick(12);
    rst <= 1'b0;
    // defaults: channel k on message k, average group on 12; stalled
    txq.push_back(fexp(16'hFF00, {32'h0, src_val_i[0][15:0], 16'h0}));
    txq.push_back(fexp(16'hFF01, {32'h0, src_val_i[1][15:0], 16'h0}));
    txq.push_back(fexp(16'hFD53, {32'h0, src_val_i[12][15:0], 16'h0}));
    stall <= 1'b1;
    wr_msg(0, 16'hFF00, 16'h0064);
    wr_msg(1, 16'hFF01, 16'h0064);
    wr_msg(12, 16'hFD53, 16'h0064);
    tick(200);
    `CHK(tx_valid, 1'b1)
    stall <= 1'b0;
    wait_got(3);
    wr_msg(0, 16'hFF00, 16'h0000);
    wr_msg(1, 16'hFF01, 16'h0000);
    wr_msg(12, 16'hFD53, 16'h0000);
    tick(40);
    // every size at a random place; clamp, offset, divisor applied
    for (int i = 0; i < 7; i++) begin
      w = (i < 3) ? (1 << i) : 8 * (i - 2);
      v = $urandom % 60000;
      b = $urandom % 8;
      t = $urandom % 8;
      c = (i == 6 || v > 40000) ? 40000 : v;
      r = (c - 5 * i) / (1 + i % 3);
      d = ({32'h0, r[31:0]} & ((64'h1 << w) - 64'h1)) << (8 * b + t);
      txq.push_back(fexp(16'hFF02, d));
      src_val_i[3] <= 32'(v);
      @(posedge ref_clk);
      sig_cfg_we  <= 1'b1;
      sig_cfg_msg <= 4'h2;
      sig_cfg_idx <= 2'h0;
      sig_cfg_i   <= '{src: 5'h04, size: size_e'(i), byte_idx: 3'(b),
        bit_idx: 3'(t), res: 32'(1 + i % 3), offset: 32'(5 * i),
        min: (i == 6) ? 32'sh0000C350 : 32'sh0, max: 32'sh00009C40};
      @(posedge ref_clk);
      sig_cfg_we  <= 1'b0;
      n = got_n + 1;
      wr_msg(2, 16'hFF02, 16'h0002);
      wait_got(n);
      wr_msg(2, 16'hFF02, 16'h0000);
      tick(40);
    end
    // both fault options against both pin levels
    for (int i = 0; i < 4; i++) begin
      gen_opt_i   <= '{pf_disables: i[0], ot_shutdown: i[0]};
      power_fault <= i[1];
      over_temp   <= i[1];
      tick(6);
      `CHK(outputs_disabled_o, 1'(i[0] & i[1]))
      `CHK(shutdown_o, 1'(i[0] & i[1]))
    end
    // shut down: an enabled message must stay silent
    wr_msg(0, 16'hFF00, 16'h0001);
    tick(60);
    wr_msg(0, 16'hFF00, 16'h0000);
    gen_opt_i   <= '{pf_disables: 1'b0, ot_shutdown: 1'b1};
    power_fault <= 1'b0;
    // receive off while timeout is zero
    rx_cfg_i <= '{pgn: 16'hFF10, timeout_ms: 16'h0000, filt_en: 1'b1,
      src_addr: 8'h22, size: SZ_2BYTE, byte_idx: 3'h1, bit_idx: 3'h4,
      res: 32'sh3, offset: -32'sh7, off_thr: 32'sh64, on_thr: 32'sh7D0};
    to_n = 0;
    far_node.send({3'h6, 2'b00, 16'hFF10, 8'h22}, {32'h0, 32'h00320000});
    tick(120);
    `CHK(to_n, 0)
    rx_cfg_i.timeout_ms <= 16'h0005;
    // foreign sender dropped, then hysteresis up, hold, down
    far_node.send({3'h6, 2'b00, 16'hFF10, 8'h23}, {32'h0, 32'h00320000});
    tick(3);
    for (int i = 0; i < 3; i++) begin
      rxq.push_back(ex[i]);
      far_node.send({3'h6, 2'b00, 16'hFF10, 8'h22},
                    {32'($urandom), 4'h0, raw[i], 12'h000});
      tick(3);
    end
    to_n = 0;
    tick(120);
    `CHK(to_n, 2)
    `CHK(rxq.size(), 0)
    stop_test();
  end
endmodule

`default_nettype wire

/* frame_buffer2.sv */
// small valid/ready buffer in front of the can controller
`timescale 1ns/100ps
`default_nettype none

module frame_buffer2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];   // storage, written only on push
  logic [AW-1:0]    wr_q, wr_d;      // write pointer
  logic [AW-1:0]    rd_q, rd_d;      // read pointer
  logic [AW:0]      cnt_q, cnt_d;    // fill level
  logic             push, pop;

  // full and empty come straight from the fill level
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer arithmetic wraps at depth
  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : AW'(wr_q + 1'b1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : AW'(rd_q + 1'b1);
    end
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  // pointers and level registered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // data store needs no reset; empty hides stale words
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule

`default_nettype wire
